/* File: shared/accr_pkg.sv */
// Constants shared by the converter configuration register bank.
// Assumes a 16-bit register address space with 8-bit registers.
package accr_pkg;
    localparam int AW = 16;
    localparam int DW = 8;
    // Documented register offsets
    localparam logic [15:0] ADDR_LANE0_EMPH   = 16'h05c4;
    localparam logic [15:0] ADDR_LANE1_EMPH   = 16'h05c6;
    localparam logic [15:0] ADDR_OFFCAL_CTRL  = 16'h0701;
    localparam logic [15:0] ADDR_OFFCAL_LOCAL = 16'h073b;
    localparam logic [15:0] ADDR_DITHER       = 16'h0922;
    localparam logic [15:0] ADDR_PLL_CAL      = 16'h1222;
    localparam logic [15:0] ADDR_LINK_STARTUP = 16'h1228;
    localparam logic [15:0] ADDR_PLL_LOL      = 16'h1262;
    localparam logic [15:0] ADDR_REF_CTRL     = 16'h18a6;
    // Interrupt registers
    localparam logic [15:0] ADDR_IRQ_STATUS   = 16'h1f00;
    localparam logic [15:0] ADDR_IRQ_ENABLE   = 16'h1f01;
    localparam logic [15:0] ADDR_IRQ_CLEAR    = 16'h1f02;
    // Reset values
    localparam logic [7:0] RST_EMPH          = 8'h00;
    localparam logic [7:0] RST_OFFCAL_CTRL   = 8'h06;
    localparam logic [7:0] RST_OFFCAL_LOCAL  = 8'hbf;
    localparam logic [7:0] RST_DITHER        = 8'h70;
    localparam logic [7:0] RST_PLL_CAL       = 8'h00;
    localparam logic [7:0] RST_LINK_STARTUP  = 8'h0f;
    localparam logic [7:0] RST_PLL_LOL       = 8'h00;
    localparam logic [7:0] RST_REF_CTRL      = 8'h00;
    // Command codes
    localparam logic [7:0] DITHER_ON         = 8'h70;
    localparam logic [7:0] DITHER_OFF        = 8'h71;
    localparam logic [7:0] PLL_CAL_START     = 8'h04;
    localparam logic [7:0] PLL_CAL_NORMAL    = 8'h00;
    localparam logic [7:0] STARTUP_NORMAL    = 8'h0f;
    localparam logic [7:0] STARTUP_HOLD      = 8'h4f;
    localparam logic [7:0] LOL_CLEAR         = 8'h08;
    localparam logic [7:0] LOL_NORMAL        = 8'h00;
    localparam logic [7:0] OFFCAL_OFF        = 8'h06;
    localparam logic [7:0] OFFCAL_ON         = 8'h86;
    // Field positions
    localparam int EMPH_EN_BIT   = 7;
    localparam int EMPH_LVL_LSB  = 4;
    localparam int EMPH_LVL_W    = 3;
    localparam int OFFCAL_EN_BIT = 7;
    localparam int REF_EXT_BIT   = 0;
    localparam int REF_RW4_BIT   = 4;
    localparam logic [2:0] EMPH_LVL_MAX = 3'h4;
    // Interrupt event bits
    localparam int IRQ_W         = 4;
    localparam int EV_LOCK_LOSS  = 0;
    localparam int EV_CAL_DONE   = 1;
    localparam int EV_LOL_CLEAR  = 2;
    localparam int EV_BAD_WRITE  = 3;
endpackage

/* File: shared/accr_bus_if.sv */
// Register write path between the bank and its interrupt unit.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
interface accr_bus_if;
    logic       eventPulse0;
    logic       eventPulse1;
    logic       eventPulse2;
    logic       eventPulse3;
    logic       clrWrite;
    logic       enWrite;
    logic [7:0] wrData;
    logic [3:0] status;
    logic [3:0] enable;
    logic       irq;
    modport bank (output eventPulse0, eventPulse1, eventPulse2, eventPulse3,
                  output clrWrite, enWrite, wrData, input status, enable, irq);
    modport intr (input eventPulse0, eventPulse1, eventPulse2, eventPulse3,
                  input clrWrite, enWrite, wrData, output status, enable, irq);
endinterface

/* File: design/accr_irq_unit.sv */
// Sticky event status, enable mask and level interrupt.
// Assumes synchronous reset copy from the top and one-cycle event pulses.
`timescale 1ns/1ns
module accr_irq_unit
    import accr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstN,
    accr_bus_if.intr  bus
);
    logic [IRQ_W-1:0] events;
    assign events = {bus.eventPulse3, bus.eventPulse2, bus.eventPulse1, bus.eventPulse0};

    // Set beats clear so an event in the clear cycle survives
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            bus.status <= '0;
        end else begin
            bus.status <= (bus.status & ~(bus.clrWrite ? bus.wrData[IRQ_W-1:0] : '0)) | events;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            bus.enable <= '0;
        end else if (bus.enWrite) begin
            bus.enable <= bus.wrData[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            bus.irq <= 1'b0;
        end else begin
            bus.irq <= |(((bus.status & ~(bus.clrWrite ? bus.wrData[IRQ_W-1:0] : '0))
                         | events) & (bus.enWrite ? bus.wrData[IRQ_W-1:0] : bus.enable));
        end
    end
endmodule

/* File: design/accr_config_regs.sv */
// Configuration register bank: lane emphasis, dither, PLL calibration,
// link start-up reset, loss-of-lock clear, offset calibration, reference.
// Assumes a plain strobe port; read data valid the cycle after the strobe.
`timescale 1ns/1ns
module accr_config_regs
    import accr_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic [AW-1:0] regAddr,
    input  wire logic [DW-1:0] regWrData,
    input  wire logic          regWrite,
    input  wire logic          regRead,
    output logic      [DW-1:0] regRdData,
    input  wire logic          pllLockLost,
    input  wire logic          pllCalDone,
    output logic               laneEmphEn0,
    output logic [2:0]         laneEmphLvl0,
    output logic               laneEmphEn1,
    output logic [2:0]         laneEmphLvl1,
    output logic               ditherEnable,
    output logic               pllCalRun,
    output logic               linkStartupHold,
    output logic               lockLossFlag,
    output logic               offsetCalEnable,
    output logic               offsetCalLocalOff,
    output logic               refExternal,
    output logic               irq
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rstMeta;
    logic rstN;
    // Two flops so every register leaves reset on the same clean edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] lane0Emph;
    logic [7:0] lane1Emph;
    logic [7:0] offCalCtrl;
    logic [7:0] offCalLocal;
    logic [7:0] ditherCtrl;
    logic [7:0] pllCal;
    logic [7:0] linkStartup;
    logic [7:0] pllLol;
    logic [7:0] refCtrl;
    logic       lockLost;

    function automatic logic hit(input logic [AW-1:0] a);
        return regWrite && (regAddr == a);
    endfunction

    accr_bus_if ib ();

    // Lane emphasis: low nibble reserved, read-only zero
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            lane0Emph <= RST_EMPH;
            lane1Emph <= RST_EMPH;
        end else begin
            if (hit(ADDR_LANE0_EMPH)) begin
                lane0Emph <= {regWrData[7:4], 4'h0};
            end
            if (hit(ADDR_LANE1_EMPH)) begin
                lane1Emph <= {regWrData[7:4], 4'h0};
            end
        end
    end

    // Offset calibration main and local enables
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            offCalCtrl  <= RST_OFFCAL_CTRL;
            offCalLocal <= RST_OFFCAL_LOCAL;
        end else begin
            if (hit(ADDR_OFFCAL_CTRL)) begin
                offCalCtrl <= regWrData;
            end
            // Only bit 7 writable; low bits read back fixed pattern
            if (hit(ADDR_OFFCAL_LOCAL)) begin
                offCalLocal <= {regWrData[7], RST_OFFCAL_LOCAL[6:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    // Whole byte stored, unlisted codes included, so software reads back what it wrote
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ditherCtrl <= RST_DITHER;
        end else if (hit(ADDR_DITHER)) begin
            ditherCtrl <= regWrData;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pllCal <= RST_PLL_CAL;
        end else if (hit(ADDR_PLL_CAL)) begin
            pllCal <= regWrData;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            linkStartup <= RST_LINK_STARTUP;
        end else if (hit(ADDR_LINK_STARTUP)) begin
            linkStartup <= regWrData;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pllLol <= RST_PLL_LOL;
        end else if (hit(ADDR_PLL_LOL)) begin
            pllLol <= regWrData;
        end
    end

    // Bit 4 is a plain storage bit, bit 0 selects the external reference, the others reserved zero
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            refCtrl <= RST_REF_CTRL;
        end else if (hit(ADDR_REF_CTRL)) begin
            refCtrl <= {3'h0, regWrData[REF_RW4_BIT], 3'h0, regWrData[REF_EXT_BIT]};
        end
    end

    // ------------------------------------------------------------
    // Loss-of-lock record
    // ------------------------------------------------------------
    // A new loss in the clear cycle wins so it is never missed
    logic lolClearWr;
    always_comb begin
        lolClearWr = hit(ADDR_PLL_LOL) && (regWrData == LOL_CLEAR);
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            lockLost <= 1'b0;
        end else if (pllLockLost) begin
            lockLost <= 1'b1;
        end else if (lolClearWr) begin
            lockLost <= 1'b0;
        end
    end

    // Unrecognised command codes flag an event; value is still stored
    logic badWrite;
    always_comb begin
        badWrite = 1'b0;
        if (regWrite) begin
            unique case (regAddr)
                ADDR_DITHER:
                    badWrite = regWrData != DITHER_ON && regWrData != DITHER_OFF;
                ADDR_PLL_CAL:
                    badWrite = regWrData != PLL_CAL_START && regWrData != PLL_CAL_NORMAL;
                ADDR_LINK_STARTUP:
                    badWrite = regWrData != STARTUP_NORMAL && regWrData != STARTUP_HOLD;
                ADDR_PLL_LOL:
                    badWrite = regWrData != LOL_CLEAR && regWrData != LOL_NORMAL;
                ADDR_OFFCAL_CTRL:
                    badWrite = regWrData != OFFCAL_OFF && regWrData != OFFCAL_ON;
                ADDR_LANE0_EMPH, ADDR_LANE1_EMPH:
                    badWrite = regWrData[6:4] > EMPH_LVL_MAX;
                default:
                    badWrite = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign ib.eventPulse0 = pllLockLost;
    assign ib.eventPulse1 = pllCalDone;
    assign ib.eventPulse2 = lolClearWr;
    assign ib.eventPulse3 = badWrite;
    // A process, not an assign, so the strobe and address read inside hit are tracked
    always_comb begin
        ib.clrWrite = hit(ADDR_IRQ_CLEAR);
        ib.enWrite  = hit(ADDR_IRQ_ENABLE);
    end
    assign ib.wrData      = regWrData;

    accr_irq_unit u_irq (
        .clk  (clk),
        .rstN (rstN),
        .bus  (ib)
    );

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Read data only in the slot after the strobe, zero otherwise
    logic [DW-1:0] next_rdData;
    always_comb begin
        next_rdData = '0;
        if (regRead) begin
            unique case (regAddr)
                ADDR_LANE0_EMPH:   next_rdData = lane0Emph;
                ADDR_LANE1_EMPH:   next_rdData = lane1Emph;
                ADDR_OFFCAL_CTRL:  next_rdData = offCalCtrl;
                ADDR_OFFCAL_LOCAL: next_rdData = offCalLocal;
                ADDR_DITHER:       next_rdData = ditherCtrl;
                ADDR_PLL_CAL:      next_rdData = pllCal;
                ADDR_LINK_STARTUP: next_rdData = linkStartup;
                ADDR_PLL_LOL:      next_rdData = pllLol;
                ADDR_REF_CTRL:     next_rdData = refCtrl;
                ADDR_IRQ_STATUS:   next_rdData = {4'h0, ib.status};
                ADDR_IRQ_ENABLE:   next_rdData = {4'h0, ib.enable};
                default:           next_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regRdData <= '0;
        end else begin
            regRdData <= next_rdData;
        end
    end

    // ------------------------------------------------------------
    // Control outputs, all registered
    // ------------------------------------------------------------
    // Outputs follow the stored values one cycle later
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            laneEmphEn0  <= 1'b0;
            laneEmphLvl0 <= 3'h0;
        end else begin
            laneEmphEn0  <= lane0Emph[EMPH_EN_BIT];
            laneEmphLvl0 <= lane0Emph[EMPH_LVL_LSB +: EMPH_LVL_W];
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            laneEmphEn1  <= 1'b0;
            laneEmphLvl1 <= 3'h0;
        end else begin
            laneEmphEn1  <= lane1Emph[EMPH_EN_BIT];
            laneEmphLvl1 <= lane1Emph[EMPH_LVL_LSB +: EMPH_LVL_W];
        end
    end

    // Any byte but the off code keeps dither on, matching its reset state
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ditherEnable <= 1'b1;
        end else begin
            ditherEnable <= ditherCtrl != DITHER_OFF;
        end
    end

    // Only the start code runs calibration; anything else is normal
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pllCalRun <= 1'b0;
        end else begin
            pllCalRun <= pllCal == PLL_CAL_START;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            linkStartupHold <= 1'b0;
        end else begin
            linkStartupHold <= linkStartup == STARTUP_HOLD;
        end
    end

    // Flag lags the record by one cycle like every other control output
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            lockLossFlag <= 1'b0;
        end else begin
            lockLossFlag <= lockLost;
        end
    end

    // Local enable is passed raw; keeping it inverse is left to software
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            offsetCalEnable   <= 1'b0;
            offsetCalLocalOff <= 1'b1;
        end else begin
            offsetCalEnable   <= offCalCtrl[OFFCAL_EN_BIT];
            offsetCalLocalOff <= offCalLocal[OFFCAL_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            refExternal <= 1'b0;
        end else begin
            refExternal <= refCtrl[REF_EXT_BIT];
        end
    end

    // Second flop keeps the pin registered; it trails the status by a cycle
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irq <= 1'b0;
        end else begin
            irq <= ib.irq;
        end
    end
endmodule

/* File: bench/accr_config_regs_assertions.sv */
// Port-level checks on the converter configuration register bank.
// Assumes it is bound onto accr_config_regs from the bench top.
`timescale 1ns/1ns
module accr_config_regs_assertions
    import accr_pkg::*;
(
    input wire logic          clk,
    input wire logic          arst_n,
    input wire logic [AW-1:0] regAddr,
    input wire logic [DW-1:0] regWrData,
    input wire logic          regWrite,
    input wire logic          regRead,
    input wire logic [DW-1:0] regRdData,
    input wire logic          pllLockLost,
    input wire logic          laneEmphEn0,
    input wire logic [2:0]    laneEmphLvl0,
    input wire logic          laneEmphEn1,
    input wire logic [2:0]    laneEmphLvl1,
    input wire logic          ditherEnable,
    input wire logic          pllCalRun,
    input wire logic          linkStartupHold,
    input wire logic          lockLossFlag,
    input wire logic          offsetCalEnable,
    input wire logic          refExternal
);
    // ---------------------------------------------
    // Write decode and output relations
    // ---------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire wLane0 = regWrite && regAddr == ADDR_LANE0_EMPH;
    wire wLane1 = regWrite && regAddr == ADDR_LANE1_EMPH;
    wire wDith  = regWrite && regAddr == ADDR_DITHER;
    wire wPll   = regWrite && regAddr == ADDR_PLL_CAL;
    wire wStart = regWrite && regAddr == ADDR_LINK_STARTUP;
    wire wOff   = regWrite && regAddr == ADDR_OFFCAL_CTRL;
    wire wRef   = regWrite && regAddr == ADDR_REF_CTRL;
    // Read data must not linger past its one cycle
    rd_idle_zero_a: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data not zero outside read slot");
    lane0_fields_a: assert property (wLane0 |-> ##2
        {laneEmphEn0, laneEmphLvl0} == $past(regWrData[7:4], 2))
        else $error("lane 0 emphasis outputs wrong");
    lane1_fields_a: assert property (wLane1 |-> ##2
        {laneEmphEn1, laneEmphLvl1} == $past(regWrData[7:4], 2))
        else $error("lane 1 emphasis outputs wrong");
    dither_code_a: assert property (wDith |-> ##2
        ditherEnable == ($past(regWrData, 2) != DITHER_OFF))
        else $error("dither enable wrong");
    pll_cal_run_a: assert property (wPll |-> ##2
        pllCalRun == ($past(regWrData, 2) == PLL_CAL_START))
        else $error("pll calibration run wrong");
    startup_hold_a: assert property (wStart |-> ##2
        linkStartupHold == ($past(regWrData, 2) == STARTUP_HOLD))
        else $error("start-up hold wrong");
    loss_recorded_a: assert property (pllLockLost |-> ##2 lockLossFlag)
        else $error("loss of lock not recorded");
    offcal_enable_a: assert property (wOff |-> ##2
        offsetCalEnable == $past(regWrData[7], 2))
        else $error("offset calibration enable wrong");
    ref_select_a: assert property (wRef |-> ##2
        refExternal == $past(regWrData[0], 2))
        else $error("reference select wrong");
endmodule

/* File: bench/accr_config_regs_tb.sv */
// Self-checking bench for the converter configuration register bank.
// Assumes package, interface and design files are compiled before it.
`timescale 1ns/1ns
module accr_config_regs_tb
    import accr_pkg::*;
;
    // ---------------------------------------------
    // Stimulus, tables and checks
    // ---------------------------------------------
    logic          clk = 1'b0;
    logic          arst_n = 1'b0;
    logic [AW-1:0] regAddr = '0;
    logic [DW-1:0] regWrData = '0;
    logic          regWrite = 1'b0;
    logic          regRead = 1'b0;
    logic          pllLockLost = 1'b0;
    logic          pllCalDone = 1'b0;
    logic [DW-1:0] regRdData;
    logic          laneEmphEn0, laneEmphEn1, ditherEnable, pllCalRun, linkStartupHold;
    logic          lockLossFlag, offsetCalEnable, offsetCalLocalOff, refExternal, irq;
    logic [2:0]    laneEmphLvl0, laneEmphLvl1;
    logic [7:0]    sh [9];
    logic [7:0]    q;
    int            errors = 0;
    int            checks_done = 0;
    int            cycles = 0;
    localparam logic [15:0] ADR [9] = '{ADDR_LANE0_EMPH, ADDR_LANE1_EMPH,
        ADDR_OFFCAL_CTRL, ADDR_OFFCAL_LOCAL, ADDR_DITHER, ADDR_PLL_CAL,
        ADDR_LINK_STARTUP, ADDR_PLL_LOL, ADDR_REF_CTRL};
    localparam logic [7:0] RSTV [9] = '{8'h00, 8'h00, 8'h06, 8'hbf, 8'h70, 8'h00,
        8'h0f, 8'h00, 8'h00};
    // Writable bits; the rest read back as their reset value
    localparam logic [7:0] MSK [9] = '{8'hf0, 8'hf0, 8'hff, 8'h80, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h11};
    // Dither, PLL calibration, start-up and offset codes first; software keeps local enable inverse
    localparam logic [11:0] CORN [13] = '{{4'h4, 8'h71}, {4'h4, 8'h70},
        {4'h5, 8'h04}, {4'h5, 8'h00}, {4'h6, 8'h4f}, {4'h6, 8'h0f}, {4'h2, 8'h86},
        {4'h3, 8'h00}, {4'h2, 8'h06}, {4'h3, 8'h80}, {4'h0, 8'hcf}, {4'h1, 8'hb0},
        {4'h8, 8'hff}};
    wire [13:0] pins = {laneEmphEn0, laneEmphLvl0, laneEmphEn1, laneEmphLvl1,
        ditherEnable, pllCalRun, linkStartupHold, offsetCalEnable, offsetCalLocalOff,
        refExternal};

    accr_config_regs i_dut (.clk, .arst_n, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .pllLockLost, .pllCalDone, .laneEmphEn0, .laneEmphLvl0,
        .laneEmphEn1, .laneEmphLvl1, .ditherEnable, .pllCalRun, .linkStartupHold,
        .lockLossFlag, .offsetCalEnable, .offsetCalLocalOff, .refExternal, .irq);

    always #20 clk = ~clk;

    function automatic logic [13:0] expPins();
        return {sh[0][7:4], sh[1][7:4], sh[4] != 8'h71, sh[5] == 8'h04,
            sh[6] == 8'h4f, sh[2][7], sh[3][7], sh[8][0]};
    endfunction

    task automatic chk(string n, logic [13:0] e, logic [13:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite  <= 1'b0;
    endtask

    task automatic rd(logic [15:0] a, logic [7:0] e, string n);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 q = regRdData;
        chk(n, e, q);
    endtask

    task automatic doReset();
        arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 9; k++) begin
            sh[k] = RSTV[k];
            rd(ADR[k], RSTV[k], "reset value");
        end
        chk("reset pins", expPins(), pins);
        chk("reset flags", 14'h0, {lockLossFlag, irq});
    endtask

    task automatic final_report();
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        logic [3:0] k;
        logic [7:0] d;
        void'($urandom(72));
        doReset();
        wr(16'h0123, 8'hff);
        rd(16'h0123, 8'h00, "unmapped read");
        for (int i = 0; i < 70; i++) begin
            if (i < 13) begin
                k = CORN[i][11:8];
                d = CORN[i][7:0];
            end else begin
                k = 4'($urandom % 9);
                d = 8'($urandom);
                if (k == 4'h3) begin
                    d[7] = ~sh[2][7];
                end
            end
            wr(ADR[k], d);
            sh[k] = (d & MSK[k]) | (RSTV[k] & ~MSK[k]);
            rd(ADR[k], sh[k], "readback");
            chk("control pins", expPins(), pins);
            if (k == 4'h2) begin
                wr(ADR[3], {~sh[2][7], 7'h00});
                sh[3] = {~sh[2][7], RSTV[3][6:0]};
            end
        end
        wr(ADDR_IRQ_CLEAR, 8'h0f);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        @(posedge clk);
        pllLockLost <= 1'b1;
        @(posedge clk);
        pllLockLost <= 1'b0;
        rd(ADDR_IRQ_STATUS, 8'h01, "status after loss");
        chk("loss and irq", 14'h3, {lockLossFlag, irq});
        wr(ADDR_IRQ_ENABLE, 8'h00);
        wr(ADDR_PLL_LOL, 8'h08);
        rd(ADDR_IRQ_STATUS, 8'h05, "status after clear code");
        chk("cleared and masked", 14'h0, {lockLossFlag, irq});
        @(posedge clk);
        pllCalDone <= 1'b1;
        @(posedge clk);
        pllCalDone <= 1'b0;
        wr(ADDR_IRQ_CLEAR, 8'h05);
        wr(ADDR_IRQ_ENABLE, 8'h02);
        rd(ADDR_IRQ_STATUS, 8'h02, "status cal done");
        chk("irq cal done", 14'h1, {13'h0, irq});
        wr(ADDR_IRQ_CLEAR, 8'h02);
        rd(ADDR_IRQ_CLEAR, 8'h00, "clear reads zero");
        chk("irq cleared", 14'h0, {13'h0, irq});
        wr(ADDR_PLL_CAL, 8'h33);
        rd(ADDR_IRQ_STATUS, 8'h08, "unlisted code event");
        doReset();
        final_report();
    end
endmodule

bind accr_config_regs accr_config_regs_assertions i_chk (.clk, .arst_n, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .pllLockLost, .laneEmphEn0,
    .laneEmphLvl0, .laneEmphEn1, .laneEmphLvl1, .ditherEnable, .pllCalRun,
    .linkStartupHold, .lockLossFlag, .offsetCalEnable, .refExternal);
